//--- fpu_cond_exc.sv
// Floating-point predicate evaluator, vector assignment and F-line exception entry
// Operation
// - GT/OGT: true only if NaN, Z, N clear
// - NGT/ULE: true if NaN, Z or N set
// - GE/OGE: Z set, or NaN and N clear
// - NGE/ULT: NaN, or N with Z clear
// - LT/OLT and complements NLT/UGE
// - LE/OLE and complements NLE/UGT
// - GL/OGL true if NaN, Z clear; complements
// - GLE/OR true if NaN clear; complements
// - F, T, EQ, NE and signaling variants
// - Vector 11 for unimplemented and F-line
// - Vectors 48 through 55 for arithmetic exceptions
// - Top nibble all ones means F-line pattern
// - F-line illegal: vector 11, format zero frame
// - Breakpoint acknowledge ended reports illegal instruction
// - Transcendental and similar operations flagged unimplemented
// - Drain earlier FP work and pending exceptions
// - Operand fetch after earlier reads finished
// - Access error restarts the unimplemented instruction
// - Keep extended operand; unimplemented beats unsupported type
// - Copy status, supervisor, clear trace, format two
// - Saved PC is next instruction; refill first
// - Condition bits from result type only
// - Signaling tests flag NaN, EQ/NE included
`timescale 1ns/10ps
`default_nettype none
module fpu_cond_exc (
  input  wire logic        mclk,
  input  wire logic        rst,
  // Predicate test
  input  wire logic [5:0]  predicate,
  input  wire logic [3:0]  fp_condition_bits,
  output logic             predicate_true,
  output logic             unordered_branch_flag,
  // Result classification
  input  wire logic        result_valid,
  input  wire logic        result_sign,
  input  wire logic        result_zero,
  input  wire logic        result_inf,
  input  wire logic        result_nan,
  output logic [3:0]       next_condition_bits,
  // Arithmetic exception vector lookup, index 0 unordered .. 7 unsupported type
  input  wire logic [2:0]  arith_exc_index,
  output logic [7:0]       arith_vector,
  output logic [9:0]       arith_vector_offset,
  // Instruction issue
  input  wire logic        insn_valid,
  input  wire logic [15:0] insn_word,
  input  wire logic [15:0] insn_ext,
  input  wire logic        insn_native,
  input  wire logic [31:0] next_pc,
  input  wire logic [31:0] calc_ea,
  input  wire logic        needs_mem_operand,
  output logic             insn_hold,
  // Breakpoint acknowledge cycle
  input  wire logic        bkpt_ack_cycle,
  input  wire logic        transfer_ack,
  input  wire logic        transfer_error_ack,
  // Pipeline handshakes
  input  wire logic        fp_pipe_empty,
  input  wire logic        pending_exc,
  input  wire logic        reads_done,
  output logic             operand_fetch_req,
  input  wire logic        operand_fetch_done,
  input  wire logic [79:0] operand_ext,
  input  wire logic        access_error,
  output logic             restart_insn,
  input  wire logic        refill_done,
  // Processor state
  input  wire logic [15:0] processor_status_word,
  output logic [15:0]      new_status_word,
  output logic             status_write,
  // Exception frame
  output logic             exc_start,
  output logic [7:0]       exc_vector,
  output logic [3:0]       frame_format,
  output logic [7:0]       frame_words,
  output logic [15:0]      frame_vector_offset,
  output logic [31:0]      frame_pc,
  output logic [15:0]      frame_status,
  output logic [31:0]      frame_ea,
  output logic             illegal_insn,
  output logic [79:0]      saved_operand,
  output logic             handler_go
);
  ////////////////////////////////////////////////////////////////////////////
  // Predicate evaluation
  logic nan_b;
  logic zero_b;
  logic neg_b;
  logic base_true;
  assign nan_b  = fp_condition_bits[fpu_cond_pkg::COND_NAN];
  assign zero_b = fp_condition_bits[fpu_cond_pkg::COND_ZERO];
  assign neg_b  = fp_condition_bits[fpu_cond_pkg::COND_NEG];

  always_comb begin
    unique case (predicate[3:0])
      4'h0: base_true = 1'b0;
      4'h1: base_true = zero_b;
      4'h2: base_true = !(nan_b | zero_b | neg_b);
      4'h3: base_true = zero_b | !(nan_b | neg_b);
      4'h4: base_true = neg_b & !(nan_b | zero_b);
      4'h5: base_true = zero_b | (neg_b & !nan_b);
      4'h6: base_true = !(nan_b | zero_b);
      4'h7: base_true = !nan_b;
      4'h8: base_true = nan_b;
      4'h9: base_true = nan_b | zero_b;
      4'hA: base_true = nan_b | !(neg_b | zero_b);
      4'hB: base_true = nan_b | zero_b | !neg_b;
      4'hC: base_true = nan_b | (neg_b & !zero_b);
      4'hD: base_true = nan_b | zero_b | neg_b;
      4'hE: base_true = !zero_b;
      default: base_true = 1'b1;
    endcase
  end

  assign predicate_true = base_true & !predicate[5];
  assign unordered_branch_flag = predicate[4] & nan_b & !predicate[5];

  ////////////////////////////////////////////////////////////////////////////
  // Condition bit generation
  // Result type only
  always_comb begin
    next_condition_bits = fp_condition_bits;
    if (result_valid) begin
      next_condition_bits[fpu_cond_pkg::COND_NEG]  = result_sign;
      next_condition_bits[fpu_cond_pkg::COND_NAN]  = result_nan;
      next_condition_bits[fpu_cond_pkg::COND_ZERO] = result_zero & !result_nan;
      next_condition_bits[fpu_cond_pkg::COND_INF]  = result_inf & !result_nan & !result_zero;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector table
  // Arithmetic vectors 48..55
  assign arith_vector = fpu_cond_pkg::VEC_UNORDERED + {5'h00, arith_exc_index};
  assign arith_vector_offset = {arith_vector, 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode
  function automatic logic is_unimpl(input logic [15:0] w, input logic [15:0] e);
    logic [6:0] op;
    logic hit;
    op = e[6:0];
    hit = 1'b0;
    if (w[15:12] == fpu_cond_pkg::FLINE_TOP && w[11:9] == fpu_cond_pkg::FP_COPROC_ID
        && w[8:6] == 3'h0) begin
      if (e[15:13] == fpu_cond_pkg::CLASS_CONST_ROM
          && e[15:10] == fpu_cond_pkg::CONST_ROM_MODE)
        hit = 1'b1;
      else if (!e[15] && !e[13]) begin
        unique case (op)
          fpu_cond_pkg::OP_INT, fpu_cond_pkg::OP_SINH, fpu_cond_pkg::OP_INTRZ,
          fpu_cond_pkg::OP_LOGNP1, fpu_cond_pkg::OP_ETOXM1, fpu_cond_pkg::OP_TANH,
          fpu_cond_pkg::OP_ATAN, fpu_cond_pkg::OP_ASIN, fpu_cond_pkg::OP_ATANH,
          fpu_cond_pkg::OP_SIN, fpu_cond_pkg::OP_TAN, fpu_cond_pkg::OP_ETOX,
          fpu_cond_pkg::OP_TWOTOX, fpu_cond_pkg::OP_TENTOX, fpu_cond_pkg::OP_LOGN,
          fpu_cond_pkg::OP_LOG10, fpu_cond_pkg::OP_LOG2, fpu_cond_pkg::OP_COSH,
          fpu_cond_pkg::OP_ACOS, fpu_cond_pkg::OP_COS, fpu_cond_pkg::OP_GETEXP,
          fpu_cond_pkg::OP_GETMAN, fpu_cond_pkg::OP_MOD, fpu_cond_pkg::OP_REM,
          fpu_cond_pkg::OP_SCALE: hit = 1'b1;
          default: hit = (op[6:3] == fpu_cond_pkg::OP_SINCOS_HI);
        endcase
      end
    end
    return hit;
  endfunction

  logic fline;
  logic unimpl_hit;
  logic illegal_hit;
  assign fline = insn_word[15:12] == fpu_cond_pkg::FLINE_TOP;
  assign unimpl_hit = insn_valid & fline & !insn_native & is_unimpl(insn_word, insn_ext);
  assign illegal_hit = (insn_valid & fline & !insn_native & !is_unimpl(insn_word, insn_ext))
                       | (bkpt_ack_cycle & (transfer_ack | transfer_error_ack));

  ////////////////////////////////////////////////////////////////////////////
  // Exception entry sequencer
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_DRAIN  = 6'b000010,
    ST_WAITRD = 6'b000100,
    ST_FETCH  = 6'b001000,
    ST_ENTRY  = 6'b010000,
    ST_REFILL = 6'b100000
  } seq_state_t;

  seq_state_t state;
  logic [15:0] saved_word;
  logic [15:0] saved_ext;
  logic [31:0] saved_pc;
  logic [31:0] saved_ea;
  logic        want_mem;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: if (unimpl_hit) state <= ST_DRAIN;
        ST_DRAIN: if (fp_pipe_empty && !pending_exc) state <= ST_WAITRD;
        ST_WAITRD: begin
          if (access_error) state <= ST_IDLE;
          else if (reads_done) state <= want_mem ? ST_FETCH : ST_ENTRY;
        end
        ST_FETCH: begin
          if (access_error) state <= ST_IDLE;
          else if (operand_fetch_done) state <= ST_ENTRY;
        end
        ST_ENTRY: state <= ST_REFILL;
        ST_REFILL: if (refill_done) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      saved_word <= fpu_cond_pkg::RESET_WORD;
      saved_ext  <= fpu_cond_pkg::RESET_WORD;
      saved_pc   <= fpu_cond_pkg::RESET_LONG;
      saved_ea   <= fpu_cond_pkg::RESET_LONG;
      want_mem   <= 1'b0;
    end else if (state == ST_IDLE && unimpl_hit) begin
      saved_word <= insn_word;
      saved_ext  <= insn_ext;
      saved_pc   <= next_pc;
      saved_ea   <= calc_ea;
      want_mem   <= needs_mem_operand;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) saved_operand <= 80'h0;
    else if (state == ST_FETCH && operand_fetch_done && !access_error)
      saved_operand <= operand_ext;
  end

  assign insn_hold = state != ST_IDLE;
  assign operand_fetch_req = state == ST_FETCH;
  assign handler_go = state == ST_REFILL && refill_done;

  // Frame outputs and restart
  always_ff @(posedge mclk) begin
    if (rst) begin
      exc_start           <= 1'b0;
      illegal_insn        <= 1'b0;
      restart_insn        <= 1'b0;
      status_write        <= 1'b0;
      exc_vector          <= 8'h00;
      frame_format        <= 4'h0;
      frame_words         <= 8'h00;
      frame_vector_offset <= fpu_cond_pkg::RESET_WORD;
      frame_pc            <= fpu_cond_pkg::RESET_LONG;
      frame_status        <= fpu_cond_pkg::RESET_WORD;
      frame_ea            <= fpu_cond_pkg::RESET_LONG;
      new_status_word     <= fpu_cond_pkg::RESET_WORD;
    end else begin
      exc_start    <= 1'b0;
      illegal_insn <= 1'b0;
      status_write <= 1'b0;
      restart_insn <= (state == ST_WAITRD || state == ST_FETCH) && access_error;
      if (state == ST_ENTRY) begin
        exc_start           <= 1'b1;
        status_write        <= 1'b1;
        exc_vector          <= fpu_cond_pkg::VEC_FLINE;
        frame_format        <= fpu_cond_pkg::FRAME_FMT_TWO;
        frame_words         <= 8'h00;
        frame_vector_offset <= {fpu_cond_pkg::FRAME_FMT_TWO, 2'b00,
                                fpu_cond_pkg::VEC_FLINE, 2'b00};
        frame_pc            <= saved_pc;
        frame_status        <= processor_status_word;
        frame_ea            <= saved_ea;
        new_status_word     <= processor_status_word;
        new_status_word[fpu_cond_pkg::SW_SUPER]    <= 1'b1;
        new_status_word[fpu_cond_pkg::SW_TRACE_HI] <= 1'b0;
        new_status_word[fpu_cond_pkg::SW_TRACE_LO] <= 1'b0;
      end else if (state == ST_IDLE && illegal_hit) begin
        exc_start           <= 1'b1;
        illegal_insn        <= 1'b1;
        status_write        <= 1'b1;
        exc_vector          <= fpu_cond_pkg::VEC_FLINE;
        frame_format        <= fpu_cond_pkg::FRAME_FMT_ZERO;
        frame_words         <= fpu_cond_pkg::FRAME_WORDS_ZERO;
        frame_vector_offset <= {fpu_cond_pkg::FRAME_FMT_ZERO, 2'b00,
                                fpu_cond_pkg::VEC_FLINE, 2'b00};
        frame_pc            <= next_pc;
        frame_status        <= processor_status_word;
        frame_ea            <= fpu_cond_pkg::RESET_LONG;
        new_status_word     <= processor_status_word;
        new_status_word[fpu_cond_pkg::SW_SUPER]    <= 1'b1;
        new_status_word[fpu_cond_pkg::SW_TRACE_HI] <= 1'b0;
        new_status_word[fpu_cond_pkg::SW_TRACE_LO] <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- fpu_cond_pkg.sv
// Constants for the floating-point condition and exception logic
package fpu_cond_pkg;
  // Condition bit positions within fp_condition_bits
  localparam int COND_NEG = 3;
  localparam int COND_ZERO = 2;
  localparam int COND_INF = 1;
  localparam int COND_NAN = 0;
  // Vector numbers
  localparam logic [7:0] VEC_FLINE = 8'h0B;
  localparam logic [7:0] VEC_UNORDERED = 8'h30;
  localparam logic [7:0] VEC_INEXACT = 8'h31;
  localparam logic [7:0] VEC_DIV_ZERO = 8'h32;
  localparam logic [7:0] VEC_UNDERFLOW = 8'h33;
  localparam logic [7:0] VEC_OPERAND_ERR = 8'h34;
  localparam logic [7:0] VEC_OVERFLOW = 8'h35;
  localparam logic [7:0] VEC_SIG_NAN = 8'h36;
  localparam logic [7:0] VEC_UNSUP_TYPE = 8'h37;
  // Frame formats
  localparam logic [3:0] FRAME_FMT_ZERO = 4'h0;
  localparam logic [3:0] FRAME_FMT_TWO = 4'h2;
  localparam logic [7:0] FRAME_WORDS_ZERO = 8'h04;
  // Status word bit positions
  localparam int SW_TRACE_HI = 15;
  localparam int SW_TRACE_LO = 14;
  localparam int SW_SUPER = 13;
  // Instruction word fields
  localparam logic [3:0] FLINE_TOP = 4'hF;
  localparam logic [2:0] FP_COPROC_ID = 3'h1;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [31:0] RESET_LONG = 32'h0000_0000;
  // Unimplemented extension opcode values (bits 6:0 of the command word)
  localparam logic [6:0] OP_INT = 7'h01;
  localparam logic [6:0] OP_SINH = 7'h02;
  localparam logic [6:0] OP_INTRZ = 7'h03;
  localparam logic [6:0] OP_LOGNP1 = 7'h06;
  localparam logic [6:0] OP_ETOXM1 = 7'h08;
  localparam logic [6:0] OP_TANH = 7'h09;
  localparam logic [6:0] OP_ATAN = 7'h0A;
  localparam logic [6:0] OP_ASIN = 7'h0C;
  localparam logic [6:0] OP_ATANH = 7'h0D;
  localparam logic [6:0] OP_SIN = 7'h0E;
  localparam logic [6:0] OP_TAN = 7'h0F;
  localparam logic [6:0] OP_ETOX = 7'h10;
  localparam logic [6:0] OP_TWOTOX = 7'h11;
  localparam logic [6:0] OP_TENTOX = 7'h12;
  localparam logic [6:0] OP_LOGN = 7'h14;
  localparam logic [6:0] OP_LOG10 = 7'h15;
  localparam logic [6:0] OP_LOG2 = 7'h16;
  localparam logic [6:0] OP_COSH = 7'h19;
  localparam logic [6:0] OP_ACOS = 7'h1C;
  localparam logic [6:0] OP_COS = 7'h1D;
  localparam logic [6:0] OP_GETEXP = 7'h1E;
  localparam logic [6:0] OP_GETMAN = 7'h1F;
  localparam logic [6:0] OP_MOD = 7'h21;
  localparam logic [6:0] OP_REM = 7'h25;
  localparam logic [6:0] OP_SCALE = 7'h26;
  localparam logic [3:0] OP_SINCOS_HI = 4'h6;
  localparam logic [2:0] CLASS_CONST_ROM = 3'h2;
  localparam logic [5:0] CONST_ROM_MODE = 6'h17;
endpackage

//--- fpu_cond_chk.sv
// Concurrent checks on the condition and exception logic ports
`timescale 1ns/10ps
`default_nettype none
module fpu_cond_chk (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [5:0]  predicate,
  input wire logic [3:0]  fp_condition_bits,
  input wire logic        predicate_true,
  input wire logic        unordered_branch_flag,
  input wire logic [2:0]  arith_exc_index,
  input wire logic [7:0]  arith_vector,
  input wire logic [9:0]  arith_vector_offset,
  input wire logic        insn_hold,
  input wire logic        bkpt_ack_cycle,
  input wire logic        transfer_ack,
  input wire logic        transfer_error_ack,
  input wire logic        reads_done,
  input wire logic        operand_fetch_req,
  input wire logic        access_error,
  input wire logic        restart_insn,
  input wire logic        refill_done,
  input wire logic        handler_go,
  input wire logic [15:0] new_status_word,
  input wire logic        status_write,
  input wire logic        exc_start,
  input wire logic [7:0]  exc_vector,
  input wire logic [3:0]  frame_format,
  input wire logic [7:0]  frame_words,
  input wire logic [15:0] frame_vector_offset,
  input wire logic        illegal_insn
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  sequence s_bkpt_end;
    bkpt_ack_cycle && (transfer_ack || transfer_error_ack) && !insn_hold;
  endsequence
  sequence s_fetch_err;
    operand_fetch_req && access_error;
  endsequence
  ////////////////////////////////////////
  a_flag_rule: assert property (unordered_branch_flag ==
    (predicate[4] && fp_condition_bits[0] && !predicate[5])) else $error("flag mismatch");
  a_never_true: assert property (predicate == 6'h00 |-> !predicate_true)
    else $error("false test true");
  a_always_true: assert property (predicate == 6'h0F |-> predicate_true)
    else $error("true test false");
  a_vector_map: assert property (arith_vector == 8'h30 + {5'h00, arith_exc_index}
    && arith_vector_offset == {arith_vector, 2'b00}) else $error("vector map");
  a_exc_vector: assert property (exc_start |-> exc_vector == 8'h0B)
    else $error("vector not 11");
  a_frame_kind: assert property (exc_start |-> (illegal_insn ?
    (frame_format == 4'h0 && frame_words == 8'h04) :
    (frame_format == 4'h2 && frame_vector_offset == 16'h202C))) else $error("frame kind");
  a_bkpt_illegal: assert property (s_bkpt_end |=> illegal_insn && exc_start)
    else $error("breakpoint not illegal");
  a_fetch_after: assert property ($rose(operand_fetch_req) |-> $past(reads_done))
    else $error("fetch before reads");
  a_fetch_restart: assert property (s_fetch_err |-> ##[1:2] restart_insn)
    else $error("no restart");
  a_super_entry: assert property (status_write |-> exc_start
    && new_status_word[15:13] == 3'b001) else $error("status entry");
  a_refill_go: assert property (handler_go |-> refill_done && insn_hold)
    else $error("handler early");
endmodule
bind fpu_cond_exc fpu_cond_chk fpu_cond_chk_inst (.mclk, .rst, .predicate,
  .fp_condition_bits, .predicate_true, .unordered_branch_flag, .arith_exc_index,
  .arith_vector, .arith_vector_offset, .insn_hold, .bkpt_ack_cycle, .transfer_ack,
  .transfer_error_ack, .reads_done, .operand_fetch_req, .access_error, .restart_insn,
  .refill_done, .handler_go, .new_status_word, .status_write, .exc_start, .exc_vector,
  .frame_format, .frame_words, .frame_vector_offset, .illegal_insn);
`default_nettype wire

//--- fp_pipe_model.sv
// Pipeline partner answering drain, read, fetch and refill handshakes
`timescale 1ns/10ps
`default_nettype none
module fp_pipe_model #(
  parameter logic [79:0] OPND = 80'h4000_C000_0000_0000_0000
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [3:0]  slow,
  input  wire logic        insn_hold,
  input  wire logic        operand_fetch_req,
  input  wire logic        exc_start,
  output logic             fp_pipe_empty,
  output logic             reads_done,
  output logic             operand_fetch_done,
  output logic [79:0]      operand_ext,
  output logic             refill_done
);
  logic [3:0] cnt;
  logic       ent;
  always_ff @(posedge mclk) begin
    if (rst || !insn_hold || exc_start) cnt <= 4'h0;
    else if (cnt != 4'hF) cnt <= cnt + 4'h1;
  end
  always_ff @(posedge mclk) begin
    if (rst || !insn_hold) ent <= 1'b0;
    else if (exc_start) ent <= 1'b1;
  end
  assign fp_pipe_empty = cnt >= slow;
  assign reads_done = cnt >= slow;
  assign operand_fetch_done = operand_fetch_req && !ent && {1'b0, cnt} >= {slow, 1'b0};
  assign operand_ext = operand_fetch_done ? OPND : ~OPND;
  assign refill_done = ent && cnt >= slow;
endmodule
`default_nettype wire

//--- tb_fpu_condition_exception_logic.sv
// Self-checking testbench for the condition and exception logic
`timescale 1ns/10ps
`default_nettype none
module tb_fpu_condition_exception_logic;
  localparam logic [79:0] OPND = 80'h4000_C000_0000_0000_0000;
  logic mclk = 1'b0, rst = 1'b1, insn_valid = 1'b0, insn_native = 1'b0;
  logic result_valid = 1'b0, result_sign = 1'b0, result_zero = 1'b0;
  logic result_inf = 1'b0, result_nan = 1'b0, needs_mem_operand = 1'b0;
  logic bkpt_ack_cycle = 1'b0, transfer_ack = 1'b0, transfer_error_ack = 1'b0;
  logic pending_exc = 1'b0, access_error = 1'b0;
  logic [5:0]  predicate = 6'h00;
  logic [3:0]  fp_condition_bits = 4'h0, slow = 4'h0, next_condition_bits, frame_format;
  logic [2:0]  arith_exc_index = 3'h0;
  logic [15:0] insn_word = 16'h0000, insn_ext = 16'h0000;
  logic [15:0] processor_status_word = 16'hC700, new_status_word;
  logic [15:0] frame_vector_offset, frame_status;
  logic [31:0] next_pc = 32'h0000_1004, calc_ea = 32'h0000_2000, frame_pc, frame_ea;
  logic [79:0] operand_ext, saved_operand;
  logic [7:0]  arith_vector, exc_vector, frame_words;
  logic [9:0]  arith_vector_offset;
  logic predicate_true, unordered_branch_flag, insn_hold, fp_pipe_empty, reads_done;
  logic operand_fetch_req, operand_fetch_done, restart_insn, refill_done, status_write;
  logic exc_start, illegal_insn, handler_go;
  int miscompares = 0;
  int samples_checked = 0;
  always #10 mclk = ~mclk;
  fpu_cond_exc fpu_cond_exc_inst (.mclk, .rst, .predicate, .fp_condition_bits,
    .predicate_true, .unordered_branch_flag, .result_valid, .result_sign, .result_zero,
    .result_inf, .result_nan, .next_condition_bits, .arith_exc_index, .arith_vector,
    .arith_vector_offset, .insn_valid, .insn_word, .insn_ext, .insn_native, .next_pc,
    .calc_ea, .needs_mem_operand, .insn_hold, .bkpt_ack_cycle, .transfer_ack,
    .transfer_error_ack, .fp_pipe_empty, .pending_exc, .reads_done, .operand_fetch_req,
    .operand_fetch_done, .operand_ext, .access_error, .restart_insn, .refill_done,
    .processor_status_word, .new_status_word, .status_write, .exc_start, .exc_vector,
    .frame_format, .frame_words, .frame_vector_offset, .frame_pc, .frame_status,
    .frame_ea, .illegal_insn, .saved_operand, .handler_go);
  fp_pipe_model #(.OPND(OPND)) fp_pipe_model_inst (.mclk, .rst, .slow, .insn_hold,
    .operand_fetch_req, .exc_start, .fp_pipe_empty, .reads_done, .operand_fetch_done,
    .operand_ext, .refill_done);
  ////////////////////////////////////////
  task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic exp_pred(input logic [5:0] p, input logic [3:0] c);
    logic [15:0] t;
    t = {1'b1, !c[2], c[0] | c[2] | c[3], c[0] | (c[3] & !c[2]), c[0] | c[2] | !c[3],
         c[0] | !(c[3] | c[2]), c[0] | c[2], c[0], !c[0], !(c[0] | c[2]),
         c[2] | (c[3] & !c[0]), c[3] & !(c[0] | c[2]), c[2] | !(c[0] | c[3]),
         !(c[0] | c[2] | c[3]), c[2], 1'b0};
    return !p[5] && t[p[3:0]];
  endfunction
  task automatic issue(input logic [15:0] w, input logic [15:0] e, input logic nat,
                       input logic mem);
    @(posedge mclk);
    insn_word <= w;
    insn_ext <= e;
    insn_native <= nat;
    needs_mem_operand <= mem;
    insn_valid <= 1'b1;
    @(posedge mclk);
    insn_valid <= 1'b0;
  endtask
  task automatic wait_for(ref logic sig, input string msg);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    chk(sig, 1'b1, msg);
  endtask
  ////////////////////////////////////////
  task automatic t_predicates();
    for (int p = 0; p < 64; p++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge mclk);
        predicate <= p[5:0];
        fp_condition_bits <= c[3:0];
        @(negedge mclk);
        chk(predicate_true, exp_pred(p[5:0], c[3:0]), "predicate");
        chk(unordered_branch_flag, p[4] & !p[5] & c[0], "flag");
      end
    end
  endtask
  task automatic t_vectors();
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      arith_exc_index <= i[2:0];
      @(negedge mclk);
      chk(arith_vector, 8'h30 + i[7:0], "vector");
      chk(arith_vector_offset, 10'h0C0 + 10'(4 * i), "vector offset");
    end
  endtask
  task automatic t_cond_bits();
    logic [4:0] stim [5] = '{5'h11, 5'h14, 5'h1A, 5'h13, 5'h0F};
    logic [3:0] expv [5] = '{4'h1, 4'h4, 4'hA, 4'h1, 4'h5};
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      fp_condition_bits <= 4'h5;
      {result_valid, result_sign, result_zero, result_inf, result_nan} <= stim[i];
      @(negedge mclk);
      chk(next_condition_bits, expv[i], "condition bits");
    end
  endtask
  task automatic t_fline();
    issue(16'hFE00, 16'h0000, 1'b0, 1'b0);
    wait_for(exc_start, "no exception");
    chk({illegal_insn, frame_format, frame_words}, 13'h1004, "frame zero");
    chk(exc_vector, 8'h0B, "vector");
    issue(16'hF200, 16'h0022, 1'b1, 1'b0);
    repeat (4) @(negedge mclk) chk({exc_start, insn_hold}, 2'h0, "native trapped");
  endtask
  task automatic t_bkpt();
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      bkpt_ack_cycle <= 1'b1;
      transfer_ack <= k == 0;
      transfer_error_ack <= k == 1;
      @(posedge mclk);
      {bkpt_ack_cycle, transfer_ack, transfer_error_ack} <= 3'h0;
      @(negedge mclk);
      chk({exc_start, illegal_insn, frame_words}, 10'h304, "breakpoint");
    end
  endtask
  task automatic t_unimpl(input logic [3:0] s, input logic mem, input logic [15:0] e,
                          input logic pend);
    @(posedge mclk);
    slow <= s;
    pending_exc <= pend;
    issue(16'hF200, e, 1'b0, mem);
    if (pend) begin
      repeat (8) @(negedge mclk) chk({operand_fetch_req, exc_start}, 2'h0, "drain");
      @(posedge mclk);
      pending_exc <= 1'b0;
    end
    wait_for(exc_start, "no entry");
    chk({illegal_insn, frame_format, frame_vector_offset}, 21'h2202C, "frame two");
    chk(frame_pc, 32'h0000_1004, "saved pc");
    chk(frame_ea, 32'h0000_2000, "saved ea");
    chk({status_write, frame_status, new_status_word}, 33'h1_C700_2700, "status");
    if (mem) chk(saved_operand, OPND, "operand");
    wait_for(handler_go, "no handler");
    @(negedge mclk);
    chk(insn_hold, 1'b0, "hold stuck");
  endtask
  task automatic t_ops();
    logic [15:0] ops [7] = '{16'h000E, 16'h0021, 16'h0026, 16'h001F, 16'h0001,
                             16'h0033, 16'h5C00};
    for (int i = 0; i < 7; i++) t_unimpl(4'h0, 1'b0, ops[i], 1'b0);
  endtask
  task automatic t_fetch_error();
    @(posedge mclk);
    slow <= 4'h6;
    issue(16'hF200, 16'h000E, 1'b0, 1'b1);
    wait_for(operand_fetch_req, "no fetch");
    @(posedge mclk);
    access_error <= 1'b1;
    @(posedge mclk);
    access_error <= 1'b0;
    wait_for(restart_insn, "no restart");
    repeat (4) @(negedge mclk) chk({exc_start, insn_hold}, 2'h0, "entry after error");
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_predicates();
    t_vectors();
    t_cond_bits();
    t_fline();
    t_bkpt();
    t_unimpl(4'h0, 1'b1, 16'h000E, 1'b0);
    t_unimpl(4'h5, 1'b1, 16'h0025, 1'b1);
    t_ops();
    t_fetch_error();
    wrap_up();
  end
  initial begin
    repeat (6000) @(posedge mclk);
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
